// >>> rtl/adc_result_port.sv
// Result output port of a 16-bit sampling converter: parallel and serial
`timescale 1ns/1ns
// Summary of operation
// (RQ1) Format pin high gives straight binary, low gives twos complement.
// (RQ2) Clock source high: host clocks the serial result out.
// (RQ3) Clock source low: convert command sends previous result with 16 pulses.
// (RQ4) Half select low: parallel pins show bits 15 down to 8.
// (RQ5) Half select high: parallel pins show bits 7 down to 0.
// (RQ6) Parallel pins driven only while chip select low and read high.
// (RQ7) Host should leave top parallel pin open when reading serially.
// (RQ8) Falling edge of chip select or read/convert starts a conversion.
// (RQ9) Busy low from conversion start until the result is updated.
// (RQ10) Internal mode: exactly 16 clock pulses, clock low between conversions.
// (RQ11) External mode: after 16 bits, chain input passes to serial output.
// (RQ12) One result register feeds both parallel and serial outputs; external mode loads the serial shifter from fmt_data instead.
module adc_result_port
	import adc_result_pkg::*;
(
	input  wire logic                            clock_in,
	input  wire logic                            reset_in,
	input  wire logic                            enable_in,
	input  wire logic                            chip_select_n_in,
	input  wire logic                            read_convert_in,
	input  wire logic                            half_select_in,
	input  wire logic                            code_format_select_in,
	input  wire logic                            clock_source_select_in,
	input  wire logic                            serial_shift_clock_in,
	input  wire logic                            chain_in,
	input  wire logic [adc_result_pkg::RES_W-1:0] sample_data_in,
	input  wire logic                            sample_valid_in,
	output logic                                 sample_ready_out,
	output logic                                 conv_start_out,
	output logic                                 busy_n_out,
	output logic [adc_result_pkg::HALF_W-1:0]    par_data_out,
	output logic                                 par_oe_out,
	output logic                                 serial_shift_clock_out,
	output logic                                 serial_shift_clock_oe_out,
	output logic                                 serial_result_out
);
	import adc_result_pkg::*;

	typedef struct packed {
		logic [PIN_N-1:0]  pin_meta;
		logic [PIN_N-1:0]  pin_sync;
		logic              conv_prev;
		logic              sclk_prev;
		conv_state_t       state;
		logic [RES_W-1:0]  result;
		logic [RES_W-1:0]  tx_shift;
		logic [CNT_W-1:0]  bit_cnt;
		logic [DIV_W-1:0]  div_cnt;
		logic              int_active;
		logic              chain_hold;
		logic              sclk;
		logic              sclk_oe;
		logic              sdo;
		logic [HALF_W-1:0] par;
		logic              par_oe;
		logic              busy_n;
		logic              conv_start;
		logic              rdy;
	} port_t;

	port_t s;
	port_t next_s;
	logic [RES_W-1:0] buf_data;
	logic             buf_valid;
	logic             buf_ready;
	logic [RES_W-1:0] fmt_data;
	logic             conv_level;
	logic             start_go;
	logic             ext_fall;
	logic             ext_mode;
	logic             read_window;

	result_buffer #(.WIDTH(RES_W)) u_buffer (
		.clock_in      (clock_in),
		.reset_in      (reset_in),
		.enable_in     (enable_in),
		.in_data_in    (sample_data_in),
		.in_valid_in   (sample_valid_in),
		.in_ready_out  (buf_ready),
		.out_data_out  (buf_data),
		.out_valid_out (buf_valid),
		.out_ready_in  (s.state == ST_CONVERT)
	);

	always_comb
	begin
		next_s = s;
		next_s.pin_meta = {clock_source_select_in,
			half_select_in, code_format_select_in, chain_in,
			serial_shift_clock_in, read_convert_in, chip_select_n_in};
		next_s.pin_sync = s.pin_meta;
		next_s.rdy = buf_ready;
		ext_mode = s.pin_sync[PIN_SRC];
		next_s.sclk_oe = !ext_mode;
		read_window = !s.pin_sync[PIN_CS] && s.pin_sync[PIN_RC];
		// Chip select and read/convert are ORed; its fall starts a conversion
		conv_level = s.pin_sync[PIN_CS] | s.pin_sync[PIN_RC];
		next_s.conv_prev = conv_level;
		start_go = s.conv_prev && !conv_level && (s.state == ST_IDLE); // RQ8
		next_s.sclk_prev = s.pin_sync[PIN_SCLK];
		ext_fall = ext_mode && s.sclk_prev && !s.pin_sync[PIN_SCLK];
		// Straight binary when high, sign bit flipped when low
		fmt_data = s.pin_sync[PIN_FMT] ? buf_data
			: (buf_data ^ SIGN_FLIP); // RQ1
		next_s.conv_start = 1'b0;
		unique case (s.state)
			ST_IDLE:
			begin
				if (start_go)
				begin
					next_s.state = ST_CONVERT;
					next_s.busy_n = 1'b0; // RQ9
					next_s.conv_start = 1'b1; // RQ8
					if (!ext_mode)
					begin
						next_s.tx_shift = s.result; // RQ3
						next_s.bit_cnt = PULSE_COUNT;
						next_s.div_cnt = DIV_ZERO;
						next_s.int_active = 1'b1;
						next_s.chain_hold = s.pin_sync[PIN_CHAIN];
					end
				end
			end
			ST_CONVERT:
			begin
				if (buf_valid)
				begin
					next_s.result = fmt_data; // RQ12
					next_s.busy_n = 1'b1; // RQ9
					next_s.state = ST_IDLE;
					if (ext_mode)
					begin
						next_s.tx_shift = fmt_data; // RQ2
						next_s.bit_cnt = PULSE_COUNT;
					end
				end
			end
		endcase
		if (s.int_active)
		begin
			next_s.div_cnt = s.div_cnt + DIV_ONE;
			if (s.div_cnt == SCLK_HALF_CYC - DIV_ONE)
			begin
				next_s.div_cnt = DIV_ZERO;
				next_s.sclk = !s.sclk; // RQ10
				if (s.sclk)
				begin
					next_s.tx_shift = {s.tx_shift[MSB_IDX-1:0], 1'b0};
					next_s.bit_cnt = s.bit_cnt - CNT_ONE;
					next_s.int_active = (s.bit_cnt != CNT_ONE); // RQ10
				end
			end
		end
		else
		begin
			next_s.sclk = 1'b0; // RQ10
		end
		if (ext_fall && (s.bit_cnt != CNT_ZERO))
		begin
			next_s.tx_shift = {s.tx_shift[MSB_IDX-1:0], 1'b0}; // RQ2
			next_s.bit_cnt = s.bit_cnt - CNT_ONE;
		end
		if (s.int_active)
		begin
			next_s.sdo = s.tx_shift[MSB_IDX]; // RQ3
		end
		else if (!ext_mode)
		begin
			next_s.sdo = s.chain_hold;
		end
		else if (s.bit_cnt != CNT_ZERO)
		begin
			next_s.sdo = s.tx_shift[MSB_IDX]; // RQ2
		end
		else if (read_window)
		begin
			next_s.sdo = s.pin_sync[PIN_CHAIN]; // RQ11
		end
		next_s.par = s.pin_sync[PIN_HALF] ? s.result[HALF_W-1:0] // RQ5
			: s.result[RES_W-1:HALF_W]; // RQ4
		next_s.par_oe = read_window; // RQ6
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			s <= '0;
			s.pin_meta <= PIN_RESET;
			s.pin_sync <= PIN_RESET;
			s.conv_prev <= 1'b1;
			s.state <= ST_IDLE;
			s.result <= RESULT_RESET;
			s.busy_n <= 1'b1;
			s.sclk_oe <= 1'b1;
		end
		else if (enable_in)
		begin
			s <= next_s;
		end
	end

	assign sample_ready_out = s.rdy;
	assign conv_start_out = s.conv_start;
	assign busy_n_out = s.busy_n;
	assign par_data_out = s.par;
	assign par_oe_out = s.par_oe;
	assign serial_shift_clock_out = s.sclk;
	assign serial_shift_clock_oe_out = s.sclk_oe;
	assign serial_result_out = s.sdo;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in || !enable_in);

	sequence s_start;
		start_go;
	endsequence
	sequence s_load;
		s.state == ST_CONVERT && buf_valid;
	endsequence

	property p_start_busy;
		s_start |=> !busy_n_out && conv_start_out ##1 !conv_start_out;
	endproperty
	a_start_busy: assert property (p_start_busy) // RQ8
		else $error("start did not lower busy");

	property p_busy_hold;
		!busy_n_out && !buf_valid |=> !busy_n_out;
	endproperty
	a_busy_hold: assert property (p_busy_hold) // RQ9
		else $error("busy released before result");

	property p_load;
		s_load |=> busy_n_out && s.result == $past(fmt_data);
	endproperty
	a_load: assert property (p_load) // RQ12
		else $error("result not loaded");

	property p_format;
		s_load and !s.pin_sync[PIN_FMT] |=>
			s.result[MSB_IDX] != $past(buf_data[MSB_IDX]);
	endproperty
	a_format: assert property (p_format) // RQ1
		else $error("twos complement sign wrong");

	property p_upper;
		!s.pin_sync[PIN_HALF] |=> par_data_out == $past(s.result[15:8]);
	endproperty
	a_upper: assert property (p_upper) // RQ4
		else $error("upper half wrong");

	property p_lower;
		s.pin_sync[PIN_HALF] |=> par_data_out == $past(s.result[7:0]);
	endproperty
	a_lower: assert property (p_lower) // RQ5
		else $error("lower half wrong");

	property p_oe;
		##1 par_oe_out == $past(read_window);
	endproperty
	a_oe: assert property (p_oe) // RQ6
		else $error("parallel enable wrong");

	property p_int_start;
		s_start and !ext_mode |=> s.int_active && s.bit_cnt == PULSE_COUNT;
	endproperty
	a_int_start: assert property (p_int_start) // RQ3
		else $error("internal transmit not started");

	property p_clock_low;
		!s.int_active |-> !serial_shift_clock_out;
	endproperty
	a_clock_low: assert property (p_clock_low) // RQ10
		else $error("shift clock high when idle");

	property p_chain;
		ext_mode && s.bit_cnt == CNT_ZERO && read_window && !s.int_active
			|=> serial_result_out == $past(s.pin_sync[PIN_CHAIN]);
	endproperty
	a_chain: assert property (p_chain) // RQ11
		else $error("chain not passed");

	property p_ext_shift;
		ext_fall && s.bit_cnt != CNT_ZERO
			&& !(s.state == ST_CONVERT && buf_valid)
			|=> s.bit_cnt == $past(s.bit_cnt) - CNT_ONE;
	endproperty
	a_ext_shift: assert property (p_ext_shift) // RQ2
		else $error("external shift missed");
endmodule

// >>> rtl/adc_result_pkg.sv
// Constants and types for the converter result output port
package adc_result_pkg;
	localparam int RES_W = 16;
	localparam int HALF_W = 8;
	localparam int MSB_IDX = 15;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] PULSE_COUNT = 5'h10;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [RES_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic [RES_W-1:0] SIGN_FLIP = 16'h8000;
	// Pin synchroniser lanes
	localparam int PIN_N = 7;
	localparam int PIN_CS = 0;
	localparam int PIN_RC = 1;
	localparam int PIN_SCLK = 2;
	localparam int PIN_CHAIN = 3;
	localparam int PIN_FMT = 4;
	localparam int PIN_HALF = 5;
	localparam int PIN_SRC = 6;
	localparam logic [PIN_N-1:0] PIN_RESET = 7'h03;
	// Internal shift clock: half period, least time, rounded up
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS = 50;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] SCLK_HALF_CYC =
		DIV_W'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;
	localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
	typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_t;
endpackage

// >>> rtl/result_buffer.sv
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ns
module result_buffer
	import adc_result_pkg::*;
#(
	parameter int WIDTH = RES_W
)
(
	input  wire logic             clock_in,
	input  wire logic             reset_in,
	input  wire logic             enable_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic [1:0]            count;
	} buf_t;

	buf_t s;
	buf_t next_s;
	logic push;
	logic pop;
	logic [1:0] slot;

	assign in_ready_out = (s.count != 2'h2);
	assign out_valid_out = (s.count != 2'h0);
	assign out_data_out = s.mem[0];

	always_comb
	begin
		next_s = s;
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		slot = s.count - {1'b0, pop};
		if (pop)
		begin
			next_s.mem[0] = s.mem[1];
		end
		if (push)
		begin
			next_s.mem[slot[0]] = in_data_in;
		end
		next_s.count = s.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			s <= '0;
		end
		else if (enable_in)
		begin
			s <= next_s;
		end
	end
endmodule

// >>> tb/host_model.sv
// Host model: chip select, read/convert and external shift clock
`timescale 1ns/1ns
module host_model
(
	input  wire logic        clock_in,
	input  wire logic        sdo_in,
	output logic             cs_n_out,
	output logic             rc_out,
	output logic             sclk_out
);
	initial
	begin
		cs_n_out = 1'b1;
		rc_out = 1'b1;
		sclk_out = 1'b0;
	end
	task automatic start();
		@(posedge clock_in);
		cs_n_out <= 1'b0;
		rc_out <= 1'b1;
		repeat (4) @(posedge clock_in);
		rc_out <= 1'b0;
	endtask
	task automatic read_mode();
		@(posedge clock_in);
		rc_out <= 1'b1;
	endtask
	task automatic deselect();
		@(posedge clock_in);
		cs_n_out <= 1'b1;
	endtask
	// 80 ns clock, bit taken one cycle after it rises; idle low
	task automatic shift16(output logic [15:0] word);
		word = 16'h0000;
		repeat (16)
		begin
			@(posedge clock_in);
			sclk_out <= 1'b1;
			@(posedge clock_in);
			word = {word[14:0], sdo_in};
			repeat (3) @(posedge clock_in);
			sclk_out <= 1'b0;
			repeat (3) @(posedge clock_in);
		end
	endtask
endmodule

// >>> tb/tb.sv
// Testbench for the converter result output port
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("ERROR %0t: got %h exp %h", $time, g, e); \
		end \
	end
module tb;
	import adc_result_pkg::*;
	logic              clock_in = 1'b0;
	logic              reset_in, half, fmt, src, chain, valid, ready, en;
	logic              start, busy_n, oe, sclk, sclk_oe, sdo, cs_n, rc;
	logic              host_sclk, sclk_line;
	logic [RES_W-1:0]  data, cap, got;
	logic [HALF_W-1:0] par;
	int                pulses, bad_count, checked;
	assign sclk_line = sclk_oe ? sclk : host_sclk;
	adc_result_port u_adc_result_port (.clock_in(clock_in),
		.reset_in(reset_in), .enable_in(en), .chip_select_n_in(cs_n),
		.read_convert_in(rc), .half_select_in(half),
		.code_format_select_in(fmt), .clock_source_select_in(src),
		.serial_shift_clock_in(sclk_line), .chain_in(chain),
		.sample_data_in(data), .sample_valid_in(valid),
		.sample_ready_out(ready), .conv_start_out(start),
		.busy_n_out(busy_n), .par_data_out(par), .par_oe_out(oe),
		.serial_shift_clock_out(sclk),
		.serial_shift_clock_oe_out(sclk_oe), .serial_result_out(sdo));
	host_model u_host_model (.clock_in(clock_in), .sdo_in(sdo),
		.cs_n_out(cs_n), .rc_out(rc), .sclk_out(host_sclk));
	always #5 clock_in = ~clock_in;
	always @(posedge sclk)
	begin
		pulses++;
		cap = {cap[14:0], sdo};
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		for (n = 0; n < 500 && busy_n !== lvl; n++)
			@(posedge clock_in);
		`CHK(busy_n, lvl)
	endtask
	task automatic push(input logic [RES_W-1:0] w);
		int n;
		@(posedge clock_in);
		for (n = 0; n < 50 && ready !== 1'b1; n++)
			@(posedge clock_in);
		data <= w;
		valid <= 1'b1;
		@(posedge clock_in);
		valid <= 1'b0;
	endtask
	task automatic convert(input logic p, input logic [RES_W-1:0] w);
		u_host_model.start();
		wait_busy(1'b0);
		`CHK(start, 1'b1)
		`CHK(oe, 1'b0)
		if (p)
			push(w);
		wait_busy(1'b1);
	endtask
	task automatic read_par(input logic [RES_W-1:0] e);
		u_host_model.read_mode();
		half <= 1'b0;
		tick(5);
		`CHK(oe, 1'b1)
		`CHK(par, e[15:8])
		half <= 1'b1;
		tick(5);
		`CHK(par, e[7:0])
		u_host_model.deselect();
		tick(5);
		`CHK(oe, 1'b0)
	endtask
	task automatic s_format();
		convert(1'b1, 16'hA5C3);
		read_par(16'hA5C3);
		fmt <= 1'b0;
		convert(1'b1, 16'h1234);
		read_par(16'h1234 ^ SIGN_FLIP);
		fmt <= 1'b1;
	endtask
	// Core fills both entries while no conversion drains them
	task automatic s_buffer();
		push(16'hC3A5);
		push(16'h5AA5);
		tick(3);
		`CHK(ready, 1'b0)
		convert(1'b0, 16'h0000);
		read_par(16'hC3A5);
		convert(1'b0, 16'h0000);
		read_par(16'h5AA5);
		`CHK(ready, 1'b1)
	endtask
	task automatic s_internal();
		src <= 1'b0;
		chain <= 1'b1;
		tick(4);
		pulses = 0;
		convert(1'b1, 16'h0F0F);
		`CHK(sclk_oe, 1'b1)
		tick(200);
		`CHK(pulses, 16)
		`CHK(cap, 16'h5AA5)
		`CHK(sclk, 1'b0)
		`CHK(sdo, 1'b1)
		u_host_model.deselect();
	endtask
	// Host leaves the parallel pins unused while reading serially
	task automatic s_external();
		src <= 1'b1;
		tick(4);
		convert(1'b1, 16'h8E71);
		`CHK(sclk_oe, 1'b0)
		u_host_model.read_mode();
		tick(4);
		u_host_model.shift16(got);
		`CHK(got, 16'h8E71)
		chain <= 1'b0;
		tick(6);
		`CHK(sdo, 1'b0)
		chain <= 1'b1;
		tick(6);
		`CHK(sdo, 1'b1)
		// Clock enable low freezes the pass-through
		en <= 1'b0;
		chain <= 1'b0;
		tick(6);
		`CHK(sdo, 1'b1)
		en <= 1'b1;
		tick(6);
		`CHK(sdo, 1'b0)
		u_host_model.deselect();
	endtask
	task automatic end_of_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		{reset_in, half, fmt, src, chain, valid} = 6'h3C;
		en = 1'b1;
		data = 16'h0000;
		cap = 16'h0000;
		tick(16);
		reset_in <= 1'b0;
		tick(4);
		`CHK(busy_n, 1'b1)
		s_format();
		s_buffer();
		s_internal();
		s_external();
		end_of_test();
	end
	initial
	begin
		tick(20000);
		bad_count++;
		end_of_test();
	end
endmodule
